// [core/matrix_strobe_offset_decoder.sv]
`timescale 1ns/100ps
`include "strobe_decode_cfg.svh"
module matrix_strobe_offset_decoder (
    // Clock and reset
    input  wire logic                        clk_i,
    input  wire logic                        rst_i,
    // Switch levels, bit 0 is position 1, high means OFF
    input  wire logic [3:0]                  matrix_a_strobe_switch_i,
    input  wire logic [3:0]                  matrix_a_offset_switch_i,
    input  wire logic [3:0]                  matrix_b_strobe_switch_i,
    input  wire logic [3:0]                  matrix_b_offset_switch_i,
    // Matrix A decoded
    output strobe_decode_pkg::strobe_t       a_strobe_o,
    output logic                             a_strobe_reserved_o,
    output strobe_decode_pkg::offset_code_t  a_in_code_o,
    output strobe_decode_pkg::offset_code_t  a_out_code_o,
    output strobe_decode_pkg::xpoint_t       a_in_first_o,
    output strobe_decode_pkg::xpoint_t       a_in_last_o,
    output strobe_decode_pkg::xpoint_t       a_out_first_o,
    output strobe_decode_pkg::xpoint_t       a_out_last_o,
    // Matrix B decoded
    output strobe_decode_pkg::strobe_t       b_strobe_o,
    output logic                             b_strobe_reserved_o,
    output strobe_decode_pkg::offset_code_t  b_in_code_o,
    output strobe_decode_pkg::offset_code_t  b_out_code_o,
    output strobe_decode_pkg::xpoint_t       b_in_first_o,
    output strobe_decode_pkg::xpoint_t       b_in_last_o,
    output strobe_decode_pkg::xpoint_t       b_out_first_o,
    output strobe_decode_pkg::xpoint_t       b_out_last_o,
    // Status
    output logic                             config_valid_o
);
    import strobe_decode_pkg::*;

    logic [15:0]              sync_meta;
    logic [15:0]              sync_q;
    latch_state_t             state;
    logic [`SETTLE_WIDTH-1:0] settle_cnt;
    logic                     load;

    matrix_sw_if  a_if();
    matrix_sw_if  b_if();

    // Two-flop synchroniser; switches are static but asynchronous to clk
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            sync_meta <= 16'h0000;
            sync_q    <= 16'h0000;
        end else begin
            sync_meta <= {matrix_b_offset_switch_i, matrix_b_strobe_switch_i,
                          matrix_a_offset_switch_i, matrix_a_strobe_switch_i};
            sync_q    <= sync_meta;
        end
    end

    assign a_if.strobe_switch = sync_q[3:0];
    assign a_if.offset_switch = sync_q[7:4];
    assign b_if.strobe_switch = sync_q[11:8];
    assign b_if.offset_switch = sync_q[15:12];

    matrix_switch_decode u_dec_a (
        .sw (a_if.decoder)
    );

    matrix_switch_decode u_dec_b (
        .sw (b_if.decoder)
    );

    // Wait for the synchroniser to fill and contacts to settle, then latch once
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state      <= ST_RESET;
            settle_cnt <= '0;
        end else begin
            case (state)
                ST_RESET: begin
                    state      <= ST_SETTLE;
                    settle_cnt <= '0;
                end
                ST_SETTLE: begin
                    settle_cnt <= settle_cnt + 8'h01;
                    if (settle_cnt == `SETTLE_CYCLES - 8'h01) begin
                        state <= ST_LOCKED;
                    end
                end
                ST_LOCKED: begin
                    state <= ST_LOCKED;
                end
                default: begin
                    state <= ST_RESET;
                end
            endcase
        end
    end

    assign load = (state == ST_SETTLE) && (settle_cnt == `SETTLE_CYCLES - 8'h01);

    // Values frozen after lock so the control link sees a stable address
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            a_strobe_o          <= `STROBE_RESERVED;
            a_strobe_reserved_o <= 1'b1;
            a_in_code_o         <= '0;
            a_out_code_o        <= '0;
            a_in_first_o        <= '0;
            a_in_last_o         <= '0;
            a_out_first_o       <= '0;
            a_out_last_o        <= '0;
            b_strobe_o          <= `STROBE_RESERVED;
            b_strobe_reserved_o <= 1'b1;
            b_in_code_o         <= '0;
            b_out_code_o        <= '0;
            b_in_first_o        <= '0;
            b_in_last_o         <= '0;
            b_out_first_o       <= '0;
            b_out_last_o        <= '0;
            config_valid_o      <= 1'b0;
        end else if (load) begin
            a_strobe_o          <= a_if.strobe;
            a_strobe_reserved_o <= a_if.strobe_reserved;
            a_in_code_o         <= a_if.in_code;
            a_out_code_o        <= a_if.out_code;
            a_in_first_o        <= a_if.in_first;
            a_in_last_o         <= a_if.in_last;
            a_out_first_o       <= a_if.out_first;
            a_out_last_o        <= a_if.out_last;
            b_strobe_o          <= b_if.strobe;
            b_strobe_reserved_o <= b_if.strobe_reserved;
            b_in_code_o         <= b_if.in_code;
            b_out_code_o        <= b_if.out_code;
            b_in_first_o        <= b_if.in_first;
            b_in_last_o         <= b_if.in_last;
            b_out_first_o       <= b_if.out_first;
            b_out_last_o        <= b_if.out_last;
            config_valid_o      <= 1'b1;
        end
    end

    a_strobe_map: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(config_valid_o) |-> a_strobe_o == $past(sync_q[3:0]))
        else $error("matrix A strobe mismatch");
    a_strobe_b: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(config_valid_o) |-> b_strobe_o == $past(sync_q[11:8]))
        else $error("matrix B strobe mismatch");
    a_reserved_flag: assert property (@(posedge clk_i) disable iff (rst_i)
        config_valid_o |-> (a_strobe_reserved_o == (a_strobe_o == 4'h0)))
        else $error("reserved flag wrong");
    a_codes_a: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(config_valid_o) |-> {a_out_code_o, a_in_code_o} == $past(sync_q[7:4]))
        else $error("matrix A offset codes wrong");
    a_codes_b: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(config_valid_o) |-> {b_out_code_o, b_in_code_o} == $past(sync_q[15:12]))
        else $error("matrix B offset codes wrong");
    a_in_block: assert property (@(posedge clk_i) disable iff (rst_i)
        config_valid_o |-> (a_in_last_o - a_in_first_o == 10'h08f)
            && (a_in_last_o == 10'h090 * a_in_code_o + 10'h090))
        else $error("input block wrong");
    a_in_block_b: assert property (@(posedge clk_i) disable iff (rst_i)
        config_valid_o |-> (b_in_last_o - b_in_first_o == 10'h08f)
            && (b_in_last_o == 10'h090 * b_in_code_o + 10'h090))
        else $error("matrix B input block wrong");
    a_out_block: assert property (@(posedge clk_i) disable iff (rst_i)
        config_valid_o |-> (b_out_last_o - b_out_first_o == 10'h08f)
            && (b_out_last_o == 10'h090 * b_out_code_o + 10'h090))
        else $error("output block wrong");
    a_out_block_a: assert property (@(posedge clk_i) disable iff (rst_i)
        config_valid_o |-> (a_out_last_o - a_out_first_o == 10'h08f)
            && (a_out_last_o == 10'h090 * a_out_code_o + 10'h090))
        else $error("matrix A output block wrong");
    a_reserved_b: assert property (@(posedge clk_i) disable iff (rst_i)
        config_valid_o |-> (b_strobe_reserved_o == (b_strobe_o == 4'h0)))
        else $error("matrix B reserved flag wrong");
    a_hold_values: assert property (@(posedge clk_i) disable iff (rst_i)
        config_valid_o |=> $stable(a_strobe_o) && $stable(b_out_code_o) && config_valid_o)
        else $error("latched values moved");
    a_lock_time: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(state == ST_SETTLE) |-> ##16 config_valid_o)
        else $error("lock latency wrong");

    // Nothing reaches the link side before the settle count runs out
    a_idle_outputs: assert property (@(posedge clk_i) disable iff (rst_i)
        !config_valid_o |-> a_strobe_reserved_o && b_strobe_reserved_o
            && a_in_last_o == 10'h000 && b_out_last_o == 10'h000)
        else $error("outputs moved before lock");
    a_hold_codes: assert property (@(posedge clk_i) disable iff (rst_i)
        config_valid_o |=> $stable(a_in_code_o) && $stable(a_out_code_o) && $stable(b_strobe_o)
            && $stable(b_in_code_o) && $stable(a_in_first_o) && $stable(b_out_last_o))
        else $error("latched codes moved");
    a_load_once: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(config_valid_o) |-> $past(state) == ST_SETTLE && state == ST_LOCKED)
        else $error("load outside settle");
    a_no_early_lock: assert property (@(posedge clk_i) disable iff (rst_i)
        state == ST_SETTLE && settle_cnt != (`SETTLE_CYCLES - 8'h01) |=> !config_valid_o)
        else $error("lock came early");
    a_locked_valid: assert property (@(posedge clk_i) disable iff (rst_i)
        state == ST_LOCKED |-> config_valid_o)
        else $error("locked without valid");
    a_reset_exit: assert property (@(posedge clk_i) disable iff (rst_i)
        state == ST_RESET |=> state == ST_SETTLE)
        else $error("reset state not left");
    a_state_onehot: assert property (@(posedge clk_i) disable iff (rst_i)
        $onehot(state))
        else $error("state code not one-hot");
    a_settle_bound: assert property (@(posedge clk_i) disable iff (rst_i)
        state == ST_SETTLE |-> settle_cnt < `SETTLE_CYCLES)
        else $error("settle count overran");

    // Scenarios the bench is expected to reach
    c_locked: cover property (@(posedge clk_i) $rose(config_valid_o));
    c_reserved: cover property (@(posedge clk_i) $rose(config_valid_o) && a_strobe_reserved_o);
    c_b_reserved: cover property (@(posedge clk_i) $rose(config_valid_o) && b_strobe_reserved_o);
    c_top_block: cover property (@(posedge clk_i) config_valid_o && a_out_code_o == 2'h3);
    c_top_input: cover property (@(posedge clk_i) $rose(config_valid_o) && b_in_code_o == 2'h3);
endmodule

// [core/strobe_decode_cfg.svh]
`ifndef STROBE_DECODE_CFG_SVH
`define STROBE_DECODE_CFG_SVH

`define SW_WIDTH          4
`define STROBE_WIDTH      4
`define CODE_WIDTH        2
`define XP_WIDTH          10
`define BLOCK_SIZE        10'h090
`define IN_CODE_LSB       0
`define OUT_CODE_LSB      2
`define STROBE_RESERVED   4'h0
`define SETTLE_CYCLES     8'h10
`define SETTLE_WIDTH      8

`endif

// [core/strobe_decode_pkg.sv]
package strobe_decode_pkg;
    `include "strobe_decode_cfg.svh"

    typedef logic [`STROBE_WIDTH-1:0] strobe_t;
    typedef logic [`CODE_WIDTH-1:0]   offset_code_t;
    typedef logic [`XP_WIDTH-1:0]     xpoint_t;

    typedef enum logic [2:0] {
        ST_RESET  = 3'b001,
        ST_SETTLE = 3'b010,
        ST_LOCKED = 3'b100
    } latch_state_t;
endpackage

// [core/matrix_sw_if.sv]
`timescale 1ns/100ps
interface matrix_sw_if;
    import strobe_decode_pkg::*;
    logic [3:0]   strobe_switch;
    logic [3:0]   offset_switch;
    strobe_t      strobe;
    logic         strobe_reserved;
    offset_code_t in_code;
    offset_code_t out_code;
    xpoint_t      in_first;
    xpoint_t      in_last;
    xpoint_t      out_first;
    xpoint_t      out_last;

    modport decoder (
        input  strobe_switch,
        input  offset_switch,
        output strobe,
        output strobe_reserved,
        output in_code,
        output out_code,
        output in_first,
        output in_last,
        output out_first,
        output out_last
    );
    modport user (
        output strobe_switch,
        output offset_switch,
        input  strobe,
        input  strobe_reserved,
        input  in_code,
        input  out_code,
        input  in_first,
        input  in_last,
        input  out_first,
        input  out_last
    );
endinterface

// [core/matrix_switch_decode.sv]
`timescale 1ns/100ps
`include "strobe_decode_cfg.svh"
module matrix_switch_decode (
    matrix_sw_if.decoder sw
);
    import strobe_decode_pkg::*;

    // Switch OFF reads high, so the raw level is the binary weight
    function automatic xpoint_t block_first(input offset_code_t c);
        block_first = xpoint_t'(`BLOCK_SIZE * c + 10'h001);
    endfunction

    function automatic xpoint_t block_last(input offset_code_t c);
        block_last = xpoint_t'(`BLOCK_SIZE * (c + 10'h001));
    endfunction

    always_comb begin
        sw.strobe          = sw.strobe_switch;
        sw.strobe_reserved = (sw.strobe_switch == `STROBE_RESERVED);
        sw.in_code         = sw.offset_switch[`IN_CODE_LSB +: `CODE_WIDTH];
        sw.out_code        = sw.offset_switch[`OUT_CODE_LSB +: `CODE_WIDTH];
        sw.in_first        = block_first(sw.in_code);
        sw.in_last         = block_last(sw.in_code);
        sw.out_first       = block_first(sw.out_code);
        sw.out_last        = block_last(sw.out_code);
    end
endmodule

// [verif/switch_bank.sv]
`timescale 1ns/100ps
module switch_bank (
    // Clock
    input  wire logic        clk_i,
    // Requested slide positions, 1 is OFF
    input  wire logic [15:0] set_i,
    // Levels seen on the backplane
    output logic      [15:0] level_o
);
    // Slides move between edges, so levels change clean, never mid-cycle
    always_ff @(posedge clk_i) begin
        level_o <= set_i;
    end
endmodule

// [verif/tb.sv]
`timescale 1ns/100ps
`include "strobe_decode_cfg.svh"
module tb;
    import strobe_decode_pkg::*;
    logic         clk_i = 1'b0;
    logic         rst_i = 1'b1;
    logic [15:0]  set   = 16'hffff;
    logic [15:0]  held;
    logic [15:0]  nxt;
    logic [15:0]  exp_q[$];
    logic [15:0]  lvl;
    logic [31:0]  seed  = 32'h82d37c26;
    strobe_t      a_s, b_s;
    logic         a_r, b_r, valid;
    offset_code_t a_ic, a_oc, b_ic, b_oc;
    xpoint_t      a_if, a_il, a_of, a_ol, b_if, b_il, b_of, b_ol;
    int           bad_count = 0;
    int           n_tests   = 0;
    int           i, k;

    switch_bank i_bank (.clk_i(clk_i), .set_i(set), .level_o(lvl));

    matrix_strobe_offset_decoder i_dut (
        .clk_i(clk_i), .rst_i(rst_i),
        .matrix_a_strobe_switch_i(lvl[3:0]), .matrix_a_offset_switch_i(lvl[7:4]),
        .matrix_b_strobe_switch_i(lvl[11:8]), .matrix_b_offset_switch_i(lvl[15:12]),
        .a_strobe_o(a_s), .a_strobe_reserved_o(a_r), .a_in_code_o(a_ic), .a_out_code_o(a_oc),
        .a_in_first_o(a_if), .a_in_last_o(a_il), .a_out_first_o(a_of), .a_out_last_o(a_ol),
        .b_strobe_o(b_s), .b_strobe_reserved_o(b_r), .b_in_code_o(b_ic), .b_out_code_o(b_oc),
        .b_in_first_o(b_if), .b_in_last_o(b_il), .b_out_first_o(b_of), .b_out_last_o(b_ol),
        .config_valid_o(valid)
    );

    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction

    task automatic chk(input string nm, input logic [9:0] e, input logic [9:0] g);
        n_tests++;
        if (g !== e) begin
            bad_count++;
            $display("BAD %s expected %0d seen %0d", nm, e, g);
        end
    endtask

    // Model: OFF reads 1, lowest position is the LSB, blocks of 144
    task automatic chk_mx(input logic [7:0] sw, input strobe_t s, input logic r, input offset_code_t ic,
                          input offset_code_t oc, input xpoint_t f0, input xpoint_t l0, input xpoint_t f1,
                          input xpoint_t l1);
        int ci;
        int co;
        ci = sw[5:4];
        co = sw[7:6];
        chk("strobe", 10'(sw[3:0]), 10'(s));
        chk("reserved", 10'(sw[3:0] == 4'h0), 10'(r));
        chk("in_code", 10'(ci), 10'(ic));
        chk("out_code", 10'(co), 10'(oc));
        chk("in_first", `BLOCK_SIZE * 10'(ci) + 10'h001, f0);
        chk("in_last", `BLOCK_SIZE * 10'(ci + 1), l0);
        chk("out_first", `BLOCK_SIZE * 10'(co) + 10'h001, f1);
        chk("out_last", `BLOCK_SIZE * 10'(co + 1), l1);
    endtask

    task automatic final_report;
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    initial begin
        forever #2.5 clk_i = ~clk_i;
    end

    initial begin
        // Every strobe code on both matrices, offsets from the LFSR
        for (i = 0; i < 20; i++) begin
            seed = lfsr(seed);
            nxt  = {seed[15:12], ~4'(i), seed[7:4], 4'(i)};
            exp_q.push_back(nxt);
            @(posedge clk_i);
            set   <= nxt;
            rst_i <= 1'b1;
            repeat (5) @(posedge clk_i);
            #1;
            chk("valid_in_reset", 10'h000, 10'(valid));
            @(posedge clk_i);
            rst_i <= 1'b0;
            k = 0;
            while (valid !== 1'b1 && k < 40) begin
                @(posedge clk_i);
                #1;
                k++;
            end
            if (k >= 40) begin
                bad_count++;
                $display("BAD config_valid expected 1 seen %b", valid);
                break;
            end
            // One edge in the reset state, then the full settle count
            chk("latch_latency", 10'(`SETTLE_CYCLES) + 10'h001, 10'(k));
            held = exp_q.pop_front();
            chk_mx(held[7:0], a_s, a_r, a_ic, a_oc, a_if, a_il, a_of, a_ol);
            chk_mx(held[15:8], b_s, b_r, b_ic, b_oc, b_if, b_il, b_of, b_ol);
            // Slides moved after lock must not disturb the link addressing
            @(posedge clk_i);
            set <= ~held;
            repeat (8) @(posedge clk_i);
            #1;
            chk_mx(held[7:0], a_s, a_r, a_ic, a_oc, a_if, a_il, a_of, a_ol);
            chk_mx(held[15:8], b_s, b_r, b_ic, b_oc, b_if, b_il, b_of, b_ol);
            $display("test %0d done", i);
        end
        final_report();
    end
endmodule
